/* tb/gated_sixteen_bit_timer_tb.sv */
/*
  self-checking bench for the timer over its AXI4-Lite port.
  assumes gst_src_model feeds the gate and clock sources.
*/
`timescale 1ns/1ns
module gated_sixteen_bit_timer_tb;
  import gst_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, clk_run = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [15:0] awa = 16'h0000, ara = 16'h0000;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [22:0] gdrv = 23'h0, gsi;
  logic [12:0] csi;
  logic [7:0] edges, e0;
  logic [1:0] br, rr, resp;
  logic awr, wrr, bv, arr, rv, ovf, gev;
  int err_total = 0, total_checks = 0, n, c;
  int codes[10] = '{0, 1, 2, 3, 4, 11, 12, 22, 23, 31};
  always #5 sys_clk = ~sys_clk;
  gst_timer uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .clk_src_in(csi),
    .gate_src_in(gsi), .timer_overflow(ovf), .gate_event(gev));
  gst_src_model src (.sys_clk(sys_clk), .reset_n(reset_n),
    .gate_drive(gdrv), .clk_run(clk_run), .clk_src_in(csi),
    .gate_src_in(gsi), .edges(edges));
  ////////////////////////////////////////////////////////////
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task chkr(input string s, input int lo, input int hi,
    input logic [31:0] g);
    total_checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      err_total++;
      $display("ERROR %s expected %0d to %0d seen %h", s, lo, hi, g);
    end
  endtask
  // address and data offered together, each dropped once taken
  task wr(input logic [11:0] i, input logic [7:0] d);
    bit done;
    done = 0;
    @(posedge sys_clk);
    awa <= {2'b00, i, 2'b00};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    // no cycle limit here; only the watchdog ends a stuck wait
    while (!done) begin
      @(posedge sys_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrr) wv <= 1'b0;
      if (bv) begin
        resp = br;
        bre <= 1'b0;
        done = 1;
      end
    end
  endtask
  task rd(input logic [11:0] i);
    bit done;
    done = 0;
    @(posedge sys_clk);
    ara <= {2'b00, i, 2'b00};
    arv <= 1'b1;
    rre <= 1'b1;
    while (!done) begin
      @(posedge sys_clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        v = rdat;
        resp = rr;
        rre <= 1'b0;
        done = 1;
      end
    end
  endtask
  // count for k cycles under ctl, then stop and fetch low byte
  task run(input logic [7:0] ctl, input int k);
    wr(IDX_CONTROL, ctl);
    cyc(k);
    wr(IDX_CONTROL, 8'h00);
    rd(IDX_COUNT_LOW);
  endtask
  task pin_pulse;
    gdrv <= 23'h1;
    cyc(6);
    gdrv <= 23'h0;
    cyc(6);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // whole run is about a thousand cycles
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    reset_n <= 1'b1;
    for (c = 0; c < 6; c++) begin
      if (c != 3) rd(IDX_COUNT_LOW + 12'(c));
      if (c != 3) chk("reset value", 0, v);
    end
    wr(IDX_COUNT_HIGH, 8'hA5);
    wr(IDX_COUNT_LOW, 8'h3C);
    rd(IDX_COUNT_HIGH);
    chk("count high", 32'hA5, v);
    rd(IDX_COUNT_LOW);
    chk("count low", 32'h3C, v);
    rd(12'h0FF);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(resp));
    wr(12'h0FF, 8'h00);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(resp));
    wr(IDX_CONTROL, 8'h02);
    chk("write bresp", 32'(RESP_OKAY), 32'(resp));
    wr(IDX_COUNT_HIGH, 8'h12);
    wr(IDX_COUNT_LOW, 8'h34);
    rd(IDX_COUNT_LOW);
    chk("wide low", 32'h34, v);
    wr(IDX_COUNT_HIGH, 8'h56);
    rd(IDX_COUNT_HIGH);
    chk("wide high", 32'h12, v);
    wr(IDX_CLOCK_SOURCE, 8'(CS_SYS));
    for (c = 0; c < 4; c++) begin
      wr(IDX_CONTROL, 8'h00);
      wr(IDX_COUNT_LOW, 8'h00);
      run(8'(c * 16 + 1 + (c % 2) * 4), 64);
      chkr("prescaled", 64 >> c, (72 >> c) + 1, v);
    end
    wr(IDX_GATE_CONTROL, 8'hC0);
    wr(IDX_COUNT_LOW, 8'h00);
    run(8'h01, 40);
    chk("closed gate count", 0, v);
    wr(IDX_GATE_CONTROL, 8'h80);
    run(8'h01, 40);
    chkr("open gate count", 40, 50, v);
    wr(IDX_GATE_CONTROL, 8'h40);
    gdrv <= 23'h1;
    cyc(6);
    rd(IDX_GATE_CONTROL);
    chk("gate level", 32'h44, v);
    gdrv <= 23'h0;
    n = 0;
    repeat (10) begin
      @(posedge sys_clk);
      if (gev) n++;
    end
    chk("gate events", 1, n);
    wr(IDX_GATE_CONTROL, 8'h60);
    pin_pulse();
    rd(IDX_GATE_CONTROL);
    chk("toggle level", 32'h64, v);
    wr(IDX_GATE_CONTROL, 8'h40);
    wr(IDX_GATE_CONTROL, 8'h60);
    rd(IDX_GATE_CONTROL);
    chk("toggle cleared", 32'h60, v);
    wr(IDX_GATE_CONTROL, 8'h58);
    rd(IDX_GATE_CONTROL);
    chk("armed", 32'h58, v);
    pin_pulse();
    rd(IDX_GATE_CONTROL);
    chk("pulse done", 32'h50, v);
    wr(IDX_GATE_CONTROL, 8'h58);
    wr(IDX_GATE_CONTROL, 8'h48);
    rd(IDX_GATE_CONTROL);
    chk("armed dropped", 32'h40, v);
    for (c = 0; c < 10; c++) begin
      n = (codes[c] < 23 && codes[c] != 2) ? 1 : 0;
      wr(IDX_GATE_SOURCE, 8'(codes[c]));
      gdrv <= n ? 23'h1 << codes[c] : '1;
      cyc(6);
      rd(IDX_GATE_CONTROL);
      chk("source level", 32'h40 + n * 4, v);
    end
    gdrv <= 23'h0;
    // quarter clock ticks every fourth cycle, sync bit ignored
    wr(IDX_CLOCK_SOURCE, 8'(CS_SYS_DIV4));
    wr(IDX_COUNT_LOW, 8'h00);
    run(8'h05, 64);
    chkr("quarter clock", 16, 18, v);
    wr(IDX_CLOCK_SOURCE, 8'(CS_PIN));
    for (c = 0; c < 2; c++) begin
      wr(IDX_COUNT_LOW, 8'h00);
      e0 = edges;
      wr(IDX_CONTROL, 8'(1 + c * 4));
      clk_run <= 1'b1;
      cyc(80);
      // end the burst first so its last edge reaches the counter
      clk_run <= 1'b0;
      run(8'(1 + c * 4), 16);
      chk("pin clock count", 32'(8'(edges - e0)), v);
    end
    wr(IDX_CLOCK_SOURCE, 8'(CS_SYS));
    wr(IDX_COUNT_HIGH, 8'hFF);
    wr(IDX_COUNT_LOW, 8'hF0);
    wr(IDX_CONTROL, 8'h01);
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      if (ovf) n++;
    end
    chk("overflow pulses", 1, n);
    wr(IDX_CONTROL, 8'h00);
    rd(IDX_COUNT_HIGH);
    chk("wrapped high", 0, v);
    print_verdict();
  end
endmodule

/* tb/gst_src_model.sv */
/*
  gate and clock sources seen by the timer.
  assumes tb drives gate levels and starts pin clock bursts.
*/
`timescale 1ns/1ns
module gst_src_model (
  input wire logic sys_clk, // system clock
  input wire logic reset_n, // power-on reset
  input wire logic [22:0] gate_drive, // gate levels by code
  input wire logic clk_run, // pin clock runs while high
  output logic [12:0] clk_src_in, // clock sources by code
  output logic [22:0] gate_src_in, // gate sources by code
  output logic [7:0] edges // rising pin clock edges made
);
  logic [2:0] div;
  ////////////////////////////////////////////////////////////
  // pin clock stands low between bursts, whole periods only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div <= 3'h0;
      edges <= 8'h00;
    end else if (clk_run || div != 3'h0) begin
      div <= div + 3'h1;
      if (div == 3'h3) edges <= edges + 8'h01;
    end
  end
  // other clocks unused, held low
  assign clk_src_in = {12'h000, div[2]};
  assign gate_src_in = gate_drive;
endmodule

/* verilog/gst_pkg.sv */
/*
  constants for the gated sixteen-bit timer: register indices, field
  positions, reset values, source codes and bus answers.
  assumes a 32-bit register bus where index n sits at byte address 4*n.
*/
package gst_pkg;
  // register indices, byte address is four times the index
  localparam logic [11:0] IDX_COUNT_LOW = 12'hFCD;
  localparam logic [11:0] IDX_COUNT_HIGH = 12'hFCE;
  localparam logic [11:0] IDX_CONTROL = 12'hFCF;
  localparam logic [11:0] IDX_GATE_CONTROL = 12'hFD0;
  localparam logic [11:0] IDX_GATE_SOURCE = 12'hFD1;
  localparam logic [11:0] IDX_CLOCK_SOURCE = 12'hFD2;

  // timer_control fields
  localparam int CTL_ON = 0;
  localparam int CTL_WIDE = 1;
  localparam int CTL_SYNC = 2;
  localparam int CTL_PSC = 4;
  // gate_control fields
  localparam int GC_LEVEL = 2;
  localparam int GC_ARMED = 3;
  localparam int GC_SPM = 4;
  localparam int GC_TGL = 5;
  localparam int GC_POL = 6;
  localparam int GC_EN = 7;

  // reset values
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_GATE = 8'h00;
  localparam logic [4:0] RST_GATE_SOURCE = 5'h00;
  localparam logic [3:0] RST_CLOCK_SOURCE = 4'h0;

  // clock and gate source codes
  localparam logic [3:0] CS_PIN = 4'h0;
  localparam logic [3:0] CS_SYS_DIV4 = 4'h1;
  localparam logic [3:0] CS_SYS = 4'h2;
  localparam logic [3:0] CS_LAST_VALID = 4'hC;
  localparam logic [4:0] GSS_LAST_VALID = 5'h16;
  localparam int GATE_INPUTS = 23;
  localparam int CLOCK_INPUTS = 13;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // single-pulse acquisition states
  typedef enum logic [1:0] {GST_SP_IDLE, GST_SP_WAIT, GST_SP_OPEN} gst_sp_t;
endpackage

/* verilog/gst_timer.sv */
/*
  gated sixteen-bit up-counter with prescaler, byte or buffered word
  access, gate unit (polarity, toggle, single pulse) and an AXI4-Lite
  register slave. one instance per timer; instances differ by
  INDEX_BASE and their own overflow codes.
  assumes all source inputs are asynchronous and slow against sys_clk.
*/
// The AXI4-Lite slave port is this design's own decision.
// Summary of operation
// R1 - sixteen-bit count, reachable as high byte and low byte registers
// R2 - count is zero after power-on reset, otherwise kept
// R3 - prescale field divides input clock by 1, 2, 4 or 8
// R4 - system clock or its quarter ignore the sync bit
// R5 - other clocks: sync bit 1 skips, 0 applies resynchronisation
// R6 - wide access bit picks one 16-bit or two 8-bit operations
// R7 - enabled with gate enable counts only while gate permits; off never
// R8 - enabled without gate enable counts every prescaled clock
// R9 - gate polarity 1 counts on high gate, 0 on low gate
// R10 - toggle mode flips a gate flip-flop on each rising gate edge
// R11 - clearing toggle mode clears the toggle flip-flop
// R12 - single-pulse mode hands the gate to pulse acquisition logic
// R13 - armed bit set by software, cleared by device when pulse ends
// R14 - clearing single-pulse mode clears the armed bit
// R15 - read-only gate level shows gate state, whatever gate enable is
// R16 - five-bit gate source selects pin, timer overflows, zero cross
// R17 - codes 23 to 31 and own overflow code select nothing
// R18 - remaining codes map overflows, compare outputs, pwm, comparators
// R19 - control and gate fields reset to zero on power-on reset
// R20 - four identical instances differ in register placement and own overflow codes
// R21 - counter wraps from all ones to zero, pulsing overflow
// R22 - each falling edge of gate level pulses the gate event
// R23 - four-bit clock source: pin, system quarter, system clock
// R24 - code eleven selects second signal-measure timer overflow
// R25 - wide mode buffers high byte on low read and high write
`timescale 1ns/1ns
module gst_timer
  import gst_pkg::*;
#(
  parameter logic [11:0] INDEX_BASE = IDX_COUNT_LOW, // instance placement
  parameter logic [4:0] OWN_GATE_CODE = 5'h02, // own overflow, gate
  parameter logic [3:0] OWN_CLK_CODE = 4'h9 // own overflow, clock
) (
  input wire logic sys_clk, // 100 MHz system clock
  input wire logic reset_n, // power-on reset, async
  input wire logic clk_en, // freezes all state while low
  input wire logic [15:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [15:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [CLOCK_INPUTS-1:0] clk_src_in, // clock sources by code
  input wire logic [GATE_INPUTS-1:0] gate_src_in, // gate sources by code
  output logic timer_overflow, // one-cycle pulse on wrap
  output logic gate_event // one-cycle pulse on gate fall
);

  // R20 own codes must name overflow slots
  if (OWN_GATE_CODE > GSS_LAST_VALID || OWN_CLK_CODE > CS_LAST_VALID) begin
    $error("own overflow code out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [15:0] count_value;
  logic [7:0] high_rd_buf;
  logic [7:0] high_wr_buf;
  logic timer_on, wide_access_enable, sync_off;
  logic [1:0] prescale_select;
  logic gate_enable, gate_polarity, gate_toggle_mode;
  logic gate_single_pulse_mode, single_pulse_armed;
  logic [4:0] gate_source_code;
  logic [3:0] clock_source;
  logic gate_level;

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one write and one read at a time
  logic aw_held, w_held;
  logic [15:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write, do_read;
  logic [11:0] wr_idx, rd_idx;
  logic wr_mapped, rd_mapped, wr_byte;
  logic [31:0] next_rdata;
  logic next_rmapped;

  assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = clk_en && !w_held && !s_axi_bvalid;
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  assign do_write = clk_en && aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  // relocate so decode always compares against the base instance map
  assign wr_idx = aw_addr[13:2] - INDEX_BASE + IDX_COUNT_LOW;
  assign rd_idx = s_axi_araddr[13:2] - INDEX_BASE + IDX_COUNT_LOW;
  assign wr_mapped = aw_addr[15:14] == 2'h0 &&
                     wr_idx >= IDX_COUNT_LOW && wr_idx <= IDX_CLOCK_SOURCE;
  assign rd_mapped = s_axi_araddr[15:14] == 2'h0 &&
                     rd_idx >= IDX_COUNT_LOW && rd_idx <= IDX_CLOCK_SOURCE;
  // a write without lane 0 stores nothing but still answers okay
  assign wr_byte = do_write && wr_mapped && w_strb[0];

  // address and data are taken in either order
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 16'h0000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response, unmapped address answers slverr
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data mux, narrow registers in the low bits
  always_comb begin
    next_rdata = 32'h00000000;
    next_rmapped = rd_mapped;
    unique case (rd_idx)
      IDX_COUNT_LOW: next_rdata[7:0] = count_value[7:0];
      // R25 wide mode returns the latched high byte
      IDX_COUNT_HIGH: next_rdata[7:0] = wide_access_enable ?
                                        high_rd_buf : count_value[15:8];
      IDX_CONTROL: begin
        next_rdata[CTL_ON] = timer_on;
        next_rdata[CTL_WIDE] = wide_access_enable;
        next_rdata[CTL_SYNC] = sync_off;
        next_rdata[CTL_PSC+:2] = prescale_select;
      end
      IDX_GATE_CONTROL: begin
        next_rdata[GC_EN] = gate_enable;
        next_rdata[GC_POL] = gate_polarity;
        next_rdata[GC_TGL] = gate_toggle_mode;
        next_rdata[GC_SPM] = gate_single_pulse_mode;
        next_rdata[GC_ARMED] = single_pulse_armed;
        // R15 live gate level, read only
        next_rdata[GC_LEVEL] = gate_level;
      end
      IDX_GATE_SOURCE: next_rdata[4:0] = gate_source_code;
      IDX_CLOCK_SOURCE: next_rdata[3:0] = clock_source;
      default: next_rmapped = 1'b0;
    endcase
    if (!rd_mapped) begin
      next_rdata = 32'h00000000;
    end
  end

  // read channel
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rmapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  // R19 power-on reset clears control and gate fields
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {timer_on, wide_access_enable, sync_off} <= 3'h0;
      prescale_select <= RST_CONTROL[CTL_PSC+:2];
      {gate_enable, gate_polarity, gate_toggle_mode} <= 3'h0;
      gate_single_pulse_mode <= RST_GATE[GC_SPM];
      gate_source_code <= RST_GATE_SOURCE;
      clock_source <= RST_CLOCK_SOURCE;
    end else if (wr_byte) begin
      if (wr_idx == IDX_CONTROL) begin
        timer_on <= w_data[CTL_ON];
        wide_access_enable <= w_data[CTL_WIDE];
        sync_off <= w_data[CTL_SYNC];
        prescale_select <= w_data[CTL_PSC+:2];
      end
      if (wr_idx == IDX_GATE_CONTROL) begin
        gate_enable <= w_data[GC_EN];
        gate_polarity <= w_data[GC_POL];
        gate_toggle_mode <= w_data[GC_TGL];
        gate_single_pulse_mode <= w_data[GC_SPM];
      end
      if (wr_idx == IDX_GATE_SOURCE) begin
        gate_source_code <= w_data[4:0];
      end
      if (wr_idx == IDX_CLOCK_SOURCE) begin
        clock_source <= w_data[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers; stage one feeds stage two only
  logic [CLOCK_INPUTS-1:0] clk_s1, clk_s2;
  logic [GATE_INPUTS-1:0] gate_s1, gate_s2;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_s1 <= '0;
      clk_s2 <= '0;
      gate_s1 <= '0;
      gate_s2 <= '0;
    end else if (clk_en) begin
      clk_s1 <= clk_src_in;
      clk_s2 <= clk_s1;
      gate_s1 <= gate_src_in;
      gate_s2 <= gate_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer input clock as a tick enable
  logic ext_ok, ext_now, ext_q, ext_qq, ext_edge, in_tick;
  logic [1:0] div4;
  logic [15:0] clk_all;

  assign clk_all = {{(16-CLOCK_INPUTS){1'b0}}, clk_s2};
  // R23 codes 1 and 2 are internal; own and reserved codes give no clock; others come from the source inputs
  assign ext_ok = clock_source <= CS_LAST_VALID &&
                  clock_source != OWN_CLK_CODE &&
                  clock_source != CS_SYS_DIV4 && clock_source != CS_SYS;
  assign ext_now = ext_ok && clk_all[clock_source];
  // R5 sync bit 1 skips the extra retiming stage
  assign ext_edge = sync_off ? (ext_now && !ext_q) : (ext_q && !ext_qq);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_q <= 1'b0;
      ext_qq <= 1'b0;
      div4 <= 2'h0;
    end else if (clk_en) begin
      ext_q <= ext_now;
      ext_qq <= ext_q;
      div4 <= div4 + 2'h1;
    end
  end

  // R4 internal clocks bypass the sync choice
  always_comb begin
    unique case (clock_source)
      CS_SYS: in_tick = 1'b1;
      CS_SYS_DIV4: in_tick = div4 == DIV4_LAST;
      default: in_tick = ext_edge;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // gate unit
  logic gate_sel, gate_pol, gate_pol_q, toggle_ff, gate_mid, gate_mid_q;
  logic gate_level_q, sp_done;
  logic [31:0] gate_all;
  gst_sp_t sp_state;

  assign gate_all = {{(32-GATE_INPUTS){1'b0}}, gate_s2};
  // R16 R17 R18 R24 reserved and own codes give a low gate
  assign gate_sel = gate_source_code <= GSS_LAST_VALID &&
                    gate_source_code != OWN_GATE_CODE &&
                    gate_all[gate_source_code];
  // R9 polarity folds active level to high
  assign gate_pol = gate_polarity ? gate_sel : !gate_sel;
  // R10 toggle output replaces the gate
  assign gate_mid = gate_toggle_mode ? toggle_ff : gate_pol;
  assign sp_done = sp_state == GST_SP_OPEN && !gate_mid;
  // R12 single-pulse logic owns the gate; R15 independent of gate enable
  assign gate_level = gate_single_pulse_mode ?
                      (sp_state == GST_SP_OPEN && gate_mid) : gate_mid;

  // R10 R11 toggle flip-flop, held clear while mode is off
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      toggle_ff <= 1'b0;
      gate_pol_q <= 1'b0;
    end else if (clk_en) begin
      gate_pol_q <= gate_pol;
      if (!gate_toggle_mode) begin
        toggle_ff <= 1'b0;
      end else if (gate_pol && !gate_pol_q) begin
        toggle_ff <= !toggle_ff;
      end
    end
  end

  // R12 acquisition: wait for an edge, open for one pulse
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_state <= GST_SP_IDLE;
      gate_mid_q <= 1'b0;
    end else if (clk_en) begin
      gate_mid_q <= gate_mid;
      if (!gate_single_pulse_mode || !single_pulse_armed) begin
        sp_state <= GST_SP_IDLE;
      end else begin
        unique case (sp_state)
          GST_SP_IDLE: sp_state <= GST_SP_WAIT;
          GST_SP_WAIT: if (gate_mid && !gate_mid_q) begin
            sp_state <= GST_SP_OPEN;
          end
          GST_SP_OPEN: if (!gate_mid) begin
            sp_state <= GST_SP_IDLE;
          end
        endcase
      end
    end
  end

  // R13 R14 armed flag; a software set wins over completion
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      single_pulse_armed <= RST_GATE[GC_ARMED];
    end else if (clk_en) begin
      if (wr_byte && wr_idx == IDX_GATE_CONTROL) begin
        single_pulse_armed <= w_data[GC_ARMED] && w_data[GC_SPM];
      end else if (!gate_single_pulse_mode || sp_done) begin
        single_pulse_armed <= 1'b0;
      end
    end
  end

  // R22 gate event on every fall of the gate level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_level_q <= 1'b0;
      gate_event <= 1'b0;
    end else if (clk_en) begin
      gate_level_q <= gate_level;
      gate_event <= gate_level_q && !gate_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler and counter
  logic run, psc_done, count_inc, count_wr;
  logic [2:0] psc_cnt, psc_last;

  // R7 R8 gate enable only matters while the timer is on
  assign run = timer_on && (!gate_enable || gate_level);
  // R3 last prescaler state for 1, 2, 4, 8
  assign psc_last = 3'((4'h1 << prescale_select) - 4'h1);
  assign psc_done = psc_cnt == psc_last;
  assign count_inc = clk_en && in_tick && run && psc_done;
  assign count_wr = wr_byte && (wr_idx == IDX_COUNT_LOW ||
                    (wr_idx == IDX_COUNT_HIGH && !wide_access_enable));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      psc_cnt <= 3'h0;
    end else if (clk_en) begin
      if (!timer_on) begin
        psc_cnt <= 3'h0;
      end else if (in_tick && run) begin
        psc_cnt <= psc_done ? 3'h0 : psc_cnt + 3'h1;
      end
    end
  end

  // R1 R2 R6 R21 count; a register write beats the increment
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_value <= RST_COUNT;
      timer_overflow <= 1'b0;
    end else if (clk_en) begin
      timer_overflow <= count_inc && !count_wr && count_value == 16'hFFFF;
      if (count_wr && wr_idx == IDX_COUNT_LOW) begin
        count_value[7:0] <= w_data[7:0];
        // R25 wide write lands with the buffered high byte
        if (wide_access_enable) begin
          count_value[15:8] <= high_wr_buf;
        end
      end else if (count_wr) begin
        count_value[15:8] <= w_data[7:0];
      end else if (count_inc) begin
        count_value <= count_value + 16'h0001;
      end
    end
  end

  // R25 high-byte buffers for wide access
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      high_rd_buf <= 8'h00;
      high_wr_buf <= 8'h00;
    end else if (clk_en) begin
      if (do_read && rd_idx == IDX_COUNT_LOW && wide_access_enable) begin
        high_rd_buf <= count_value[15:8];
      end
      if (wr_byte && wr_idx == IDX_COUNT_HIGH && wide_access_enable) begin
        high_wr_buf <= w_data[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_sp_opened;
    clk_en && gate_single_pulse_mode && sp_state == GST_SP_OPEN;
  endsequence
  sequence s_sp_closed;
    clk_en && sp_done && !(wr_byte && wr_idx == IDX_GATE_CONTROL);
  endsequence

  chk_wrap_zero: assert property ( // R21
    count_inc && !count_wr && count_value == 16'hFFFF |=>
      count_value == 16'h0000 && timer_overflow)
    else $error("counter did not wrap with overflow pulse");
  chk_prescale_one: assert property ( // R3
    clk_en && timer_on && !gate_enable && prescale_select == 2'h0 &&
    clock_source == CS_SYS && !count_wr |=>
      count_value == $past(count_value) + 16'h0001)
    else $error("undivided system clock did not count");
  chk_off_hold: assert property ( // R7
    !timer_on && !count_wr |=> $stable(count_value))
    else $error("count moved while timer off");
  chk_gate_hold: assert property ( // R7
    timer_on && gate_enable && !gate_level && !count_wr |=>
      $stable(count_value))
    else $error("count moved while gate closed");
  chk_toggle_clear: assert property ( // R11
    clk_en && !gate_toggle_mode |=> !toggle_ff)
    else $error("toggle flip-flop not cleared");
  chk_spm_armed: assert property ( // R14
    clk_en && !gate_single_pulse_mode &&
    !(wr_byte && wr_idx == IDX_GATE_CONTROL) |=> !single_pulse_armed)
    else $error("armed bit survived single-pulse mode off");
  chk_pulse_done: assert property ( // R13
    s_sp_opened ##0 s_sp_closed |=> !single_pulse_armed ##1 !gate_level)
    else $error("pulse end did not clear armed bit");
  chk_gate_fall: assert property ( // R22
    clk_en && gate_level_q && !gate_level |=> gate_event)
    else $error("gate fall without event pulse");
  chk_reserved_gate: assert property ( // R17
    gate_source_code > GSS_LAST_VALID || gate_source_code == OWN_GATE_CODE
      |-> !gate_sel)
    else $error("reserved gate code passed a signal");
  chk_wide_latch: assert property ( // R25
    do_read && rd_idx == IDX_COUNT_LOW && wide_access_enable |=>
      high_rd_buf == $past(count_value[15:8]))
    else $error("high byte not latched on low read");
  chk_write_answer: assert property (
    do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write not answered next cycle");

endmodule
